/* File: lirq_pkg.sv */
package lirq_pkg;
  // Channel count of the per-channel register copies
  localparam int CHANNELS = 16;
  // Register indexes within a channel; byte address is four times the index
  localparam logic [5:0] IDX_FLAGS_A = 6'h21;
  localparam logic [5:0] IDX_FLAGS_B = 6'h22;
  localparam logic [5:0] IDX_CNT_LO = 6'h23;
  localparam logic [5:0] IDX_CNT_HI = 6'h24;
  // Monitoring channel and block-wide control indexes
  localparam logic [10:0] IDX_MON_FLAGS_B = 11'h7E2;
  localparam logic [10:0] IDX_MON_CNT_LO = 11'h7E3;
  localparam logic [10:0] IDX_MON_CNT_HI = 11'h7E4;
  localparam logic [10:0] IDX_CTRL = 11'h7F0;
  localparam logic [10:0] IDX_CNT_CTRL = 11'h7F1;
  // Flag register one bit positions
  localparam int B_SYS_ALARM = 7;
  localparam int B_LINE_ALARM = 6;
  localparam int B_PAT_LOCK = 5;
  localparam int B_LOOP_UP = 1;
  localparam int B_LOOP_DOWN = 0;
  // Flag register two bit positions
  localparam int B_SYS_BPV = 5;
  localparam int B_LINE_BPV = 4;
  localparam int B_SYS_EXZ = 3;
  localparam int B_LINE_EXZ = 2;
  localparam int B_MISMATCH = 1;
  localparam int B_WRAP = 0;
  // Edge-select control bit positions
  localparam int B_ALARM_ES = 6;
  localparam int B_PAT_ES = 5;
  localparam int B_LOOP_ES = 0;
  // Count control bit positions
  localparam int B_CNT_REQ = 0;
  localparam int B_CNT_MODE = 1;
  localparam int B_AUTO_LOOP = 3;
  // Writable and reserved bit masks, reset value
  localparam logic [7:0] FLAGS_A_MASK = 8'hE3;
  localparam logic [7:0] FLAGS_B_MASK = 8'h3F;
  localparam logic [7:0] CTRL_MASK = 8'h61;
  localparam logic [7:0] CNT_CTRL_MASK = 8'h0A;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Timing in printed units and derived cycle counts
  localparam int CLK_MHZ = 250;
  localparam int LOOP_SHORT_MS = 40;
  localparam int LOOP_LONG_MS = 5100;
  localparam int ROUND_MS = 1000;
  localparam int LOOP_SHORT_CYC = LOOP_SHORT_MS * CLK_MHZ * 1000;
  localparam int LOOP_LONG_CYC = LOOP_LONG_MS * CLK_MHZ * 1000;
  localparam int ROUND_CYC = ROUND_MS * CLK_MHZ * 1000;
endpackage

/* File: loop_code_filter.sv */
`timescale 1ns/1ps
module loop_code_filter import lirq_pkg::*; #(
  parameter int SHORT_CYC = LOOP_SHORT_CYC,
  parameter int LONG_CYC = LOOP_LONG_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw detection and hold select
  input wire logic code_seen,
  input wire logic long_hold,
  // Filtered state
  output logic state_q
);
  typedef struct packed {
    logic [30:0] cnt;
    logic state;
  } filt_t;
  filt_t s, n;
  logic [30:0] lim;

  // Persistence count, saturating so a long code never re-fires
  always_comb begin
    n = s;
    lim = long_hold ? 31'(LONG_CYC) : 31'(SHORT_CYC);
    if (!code_seen) begin
      n.cnt = '0;
    end else if (s.cnt != {31{1'b1}}) begin
      n.cnt = s.cnt + 31'h1;
    end
    n.state = code_seen && (n.cnt > lim); // [RQ19]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign state_q = s.state;
endmodule

/* File: mismatch_counter.sv */
`timescale 1ns/1ps
module mismatch_counter import lirq_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Error events and round boundary
  input wire logic err_pulse,
  input wire logic update,
  // Published count and wrap event
  output logic [15:0] count_q,
  output logic wrap_q
);
  typedef struct packed {
    logic [15:0] run;
    logic [15:0] snap;
    logic wrap;
  } cnt_t;
  cnt_t s, n;

  // Running count; the snapshot is what software sees
  always_comb begin
    n = s;
    n.wrap = err_pulse && (s.run == 16'hFFFF) && !update; // [RQ11]
    if (update) begin
      // Previous snapshot is lost if not read within the round
      n.snap = s.run + {15'h0, err_pulse}; // [RQ14] [RQ15]
      n.run = 16'h0000;
    end else begin
      n.run = s.run + {15'h0, err_pulse};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign count_q = s.snap;
  assign wrap_q = s.wrap;
endmodule

/* File: line_alarm_irq.sv */
// Contract
// RQ1 - System alarm flag sets on rising edge, or either edge when selected.
// RQ2 - Line alarm flag shares the alarm edge select.
// RQ3 - Pattern lock flag sets on rising edge, or either edge when selected.
// RQ4 - Loop-up flag sets on rising edge, or either edge per loop select.
// RQ5 - Loop-down flag follows the same loop-code edge select.
// RQ6 - Writing one clears a flag; writing zero leaves it.
// RQ7 - Every set flag is reported on the interrupt pin.
// RQ8 - Flag register two latches system and line bipolar violations, bits 5, 4.
// RQ9 - Flag register two latches system and line excess zeros, bits 3, 2.
// RQ10 - Bit 1 of flag register two latches a pattern mismatch.
// RQ11 - Bit 0 of flag register two latches a 16-bit counter wrap; a wrap in the cycle of a count update is not latched.
// RQ12 - Flag register two resets to zero; bits 7 and 6 reserved.
// RQ13 - Low count byte holds bits 7..0; high byte holds 15..8.
// RQ14 - Count bytes refresh automatically or on request, per mode bit.
// RQ15 - Software reads the count within the next round, else overwritten.
// RQ16 - Low count byte is read-only and resets to zero.
// RQ17 - Sixteen channel copies, 40 hex apart, upper eight 200 hex higher.
// RQ18 - Monitoring channel has only flag register two and count bytes.
// RQ19 - Loop-up state needs 40 ms persistence, or 5.1 s with auto loopback.
// RQ20 - Interrupt pin active while any flag of any channel is set.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module line_alarm_irq import lirq_pkg::*; #(
  parameter int LOOP_SHORT_CYCLES = LOOP_SHORT_CYC,
  parameter int LOOP_LONG_CYCLES = LOOP_LONG_CYC,
  parameter int ROUND_CYCLES = ROUND_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Level status per channel 1..16 (bit k is channel k+1)
  input wire logic [15:0] SYS_ALARM_STATE,
  input wire logic [15:0] LINE_ALARM_STATE,
  input wire logic [15:0] PATTERN_LOCK_STATE,
  input wire logic [15:0] LOOP_UP_CODE_SEEN,
  input wire logic [15:0] LOOP_DOWN_STATE,
  // Event pulses per channel 0..16 (bit 0 is the monitor channel)
  input wire logic [16:0] SYS_BPV_EVENT,
  input wire logic [16:0] LINE_BPV_EVENT,
  input wire logic [16:0] SYS_EXZ_EVENT,
  input wire logic [16:0] LINE_EXZ_EVENT,
  input wire logic [16:0] MISMATCH_EVENT,
  // Outputs to the rest of the unit
  output logic [15:0] LOOP_UP_STATE,
  output logic IRQ_N
);
  typedef struct packed {
    logic [15:0][7:0] flags_a;
    logic [16:0][7:0] flags_b;
    logic [15:0] sys_alarm_prev;
    logic [15:0] line_alarm_prev;
    logic [15:0] pat_lock_prev;
    logic [15:0] loop_up_prev;
    logic [15:0] loop_down_prev;
    logic [7:0] ctrl;
    logic [7:0] cnt_ctrl;
    logic [30:0] round_cnt;
    logic upd;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic irq_n;
  } state_t;

  state_t s, n;
  logic [1:0] rst_q;
  logic rst_n;
  logic [15:0] loop_up;
  logic [16:0][15:0] count;
  logic [16:0] wrap;
  logic [10:0] idx;
  logic [5:0] sub;
  logic [3:0] ch;
  logic [4:0] cidx;
  logic addr_ok;
  logic chan_hit;
  logic hit;
  logic [31:0] rd;
  logic done;
  logic wr;
  logic [15:0][7:0] clr_a;
  logic [16:0][7:0] clr_b;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] wbyte;
  logic manual_req;
  logic any_flag;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Address split: bank in bit 9, channel in 8..6, register in 5..0
  assign idx = PADDR[12:2];
  assign sub = idx[5:0];
  assign ch = {idx[9], idx[8:6]};
  assign cidx = {1'b0, ch} + 5'h01;
  assign addr_ok = (PADDR[15:13] == 3'h0) && (PADDR[1:0] == 2'h0);
  assign chan_hit = addr_ok && !idx[10] && (sub >= IDX_FLAGS_A)
    && (sub <= IDX_CNT_HI); // [RQ17]

  // Completion edge of an APB access; writes take effect only here
  assign done = PSEL && PENABLE && s.ready;
  assign wr = done && PWRITE && hit && PSTRB[0];
  assign wbyte = PWDATA[7:0];

  // Read decode, also tells whether the address exists
  always_comb begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    if (chan_hit) begin
      case (sub)
        IDX_FLAGS_A: begin
          rd[7:0] = s.flags_a[ch];
        end
        IDX_FLAGS_B: begin
          rd[7:0] = s.flags_b[cidx]; // [RQ12]
        end
        IDX_CNT_LO: begin
          rd[7:0] = count[cidx][7:0]; // [RQ13] [RQ16]
        end
        IDX_CNT_HI: begin
          rd[7:0] = count[cidx][15:8]; // [RQ13]
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end else if (addr_ok) begin
      // Monitor channel carries no flag register one
      case (idx)
        IDX_MON_FLAGS_B: begin
          rd[7:0] = s.flags_b[0]; // [RQ18]
        end
        IDX_MON_CNT_LO: begin
          rd[7:0] = count[0][7:0]; // [RQ18]
        end
        IDX_MON_CNT_HI: begin
          rd[7:0] = count[0][15:8];
        end
        IDX_CTRL: begin
          rd[7:0] = s.ctrl;
        end
        IDX_CNT_CTRL: begin
          rd[7:0] = s.cnt_ctrl;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end else begin
      hit = 1'b0;
    end
  end

  // Write-one-to-clear masks; counts are read-only so writes there drop
  always_comb begin
    clr_a = '0;
    clr_b = '0;
    manual_req = 1'b0;
    if (wr) begin
      if (chan_hit && (sub == IDX_FLAGS_A)) begin
        clr_a[ch] = wbyte & FLAGS_A_MASK; // [RQ6]
      end
      if (chan_hit && (sub == IDX_FLAGS_B)) begin
        clr_b[cidx] = wbyte & FLAGS_B_MASK; // [RQ6]
      end
      if (!chan_hit && (idx == IDX_MON_FLAGS_B)) begin
        clr_b[0] = wbyte & FLAGS_B_MASK; // [RQ6]
      end
      if (!chan_hit && (idx == IDX_CNT_CTRL)) begin
        manual_req = wbyte[B_CNT_REQ];
      end
    end
  end

  // Next state: flags, controls, round timer and bus answer
  always_comb begin
    n = s;
    set_a = '0;
    set_b = '0;
    // Edge-selected flags of register one
    for (int k = 0; k < CHANNELS; k++) begin
      set_a = '0;
      set_a[B_SYS_ALARM] = s.ctrl[B_ALARM_ES]
        ? (SYS_ALARM_STATE[k] ^ s.sys_alarm_prev[k])
        : (SYS_ALARM_STATE[k] & ~s.sys_alarm_prev[k]); // [RQ1]
      set_a[B_LINE_ALARM] = s.ctrl[B_ALARM_ES]
        ? (LINE_ALARM_STATE[k] ^ s.line_alarm_prev[k])
        : (LINE_ALARM_STATE[k] & ~s.line_alarm_prev[k]); // [RQ2]
      set_a[B_PAT_LOCK] = s.ctrl[B_PAT_ES]
        ? (PATTERN_LOCK_STATE[k] ^ s.pat_lock_prev[k])
        : (PATTERN_LOCK_STATE[k] & ~s.pat_lock_prev[k]); // [RQ3]
      set_a[B_LOOP_UP] = s.ctrl[B_LOOP_ES]
        ? (loop_up[k] ^ s.loop_up_prev[k])
        : (loop_up[k] & ~s.loop_up_prev[k]); // [RQ4]
      set_a[B_LOOP_DOWN] = s.ctrl[B_LOOP_ES]
        ? (LOOP_DOWN_STATE[k] ^ s.loop_down_prev[k])
        : (LOOP_DOWN_STATE[k] & ~s.loop_down_prev[k]); // [RQ5]
      // Set beats a clear landing in the same cycle
      n.flags_a[k] = (s.flags_a[k] & ~clr_a[k]) | set_a; // [RQ6]
    end
    // Event flags of register two, monitor channel included
    for (int k = 0; k <= CHANNELS; k++) begin
      set_b = '0;
      set_b[B_SYS_BPV] = SYS_BPV_EVENT[k]; // [RQ8]
      set_b[B_LINE_BPV] = LINE_BPV_EVENT[k]; // [RQ8]
      set_b[B_SYS_EXZ] = SYS_EXZ_EVENT[k]; // [RQ9]
      set_b[B_LINE_EXZ] = LINE_EXZ_EVENT[k]; // [RQ9]
      set_b[B_MISMATCH] = MISMATCH_EVENT[k]; // [RQ10]
      set_b[B_WRAP] = wrap[k]; // [RQ11]
      n.flags_b[k] = ((s.flags_b[k] & ~clr_b[k]) | set_b)
        & FLAGS_B_MASK; // [RQ12]
    end
    // Edge history
    n.sys_alarm_prev = SYS_ALARM_STATE;
    n.line_alarm_prev = LINE_ALARM_STATE;
    n.pat_lock_prev = PATTERN_LOCK_STATE;
    n.loop_up_prev = loop_up;
    n.loop_down_prev = LOOP_DOWN_STATE;
    // Control registers
    if (wr && !chan_hit && (idx == IDX_CTRL)) begin
      n.ctrl = wbyte & CTRL_MASK;
    end
    if (wr && !chan_hit && (idx == IDX_CNT_CTRL)) begin
      n.cnt_ctrl = wbyte & CNT_CTRL_MASK;
    end
    // Counting round; only runs in automatic mode
    n.upd = 1'b0;
    if (s.cnt_ctrl[B_CNT_MODE]) begin
      if (s.round_cnt >= 31'(ROUND_CYCLES - 1)) begin
        n.round_cnt = '0;
        n.upd = 1'b1; // [RQ14]
      end else begin
        n.round_cnt = s.round_cnt + 31'h1;
      end
    end else begin
      n.round_cnt = '0;
      n.upd = manual_req; // [RQ14]
    end
    // One wait state: ready rises in the second access cycle
    n.ready = 1'b0;
    n.slverr = 1'b0;
    if (PSEL && PENABLE && !s.ready) begin
      n.ready = 1'b1;
      n.slverr = !hit;
      n.rdata = hit ? rd : 32'h0000_0000;
    end
    // Pin follows the next flag values, so it rises with the last clear
    any_flag = (|n.flags_a) || (|n.flags_b);
    n.irq_n = !any_flag; // [RQ7] [RQ20]
  end

  // Single state register for flags, controls and bus; filters and counters keep their own
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.irq_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Persistence filters and error counters per channel
  generate
    for (genvar g = 0; g <= CHANNELS; g++) begin : gen_chan
      if (g < CHANNELS) begin : gen_loop
        loop_code_filter #(
          .SHORT_CYC(LOOP_SHORT_CYCLES),
          .LONG_CYC(LOOP_LONG_CYCLES)
        ) u_filt (
          .clk(CLK),
          .rst_n(rst_n),
          .code_seen(LOOP_UP_CODE_SEEN[g]),
          .long_hold(s.cnt_ctrl[B_AUTO_LOOP]),
          .state_q(loop_up[g])
        ); // [RQ19]
      end
      mismatch_counter u_cnt (
        .clk(CLK),
        .rst_n(rst_n),
        .err_pulse(MISMATCH_EVENT[g]),
        .update(s.upd),
        .count_q(count[g]),
        .wrap_q(wrap[g])
      );
    end
  endgenerate

  // Outputs straight from flops
  assign PRDATA = s.rdata;
  assign PREADY = s.ready;
  assign PSLVERR = s.slverr;
  assign IRQ_N = s.irq_n;
  assign LOOP_UP_STATE = loop_up;
endmodule

/* File: line_alarm_irq_properties.sv */
`timescale 1ns/1ps
module line_alarm_irq_properties import lirq_pkg::*; #(
  parameter int LOOP_SHORT_CYCLES = 20
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Status and events
  input wire logic [15:0] SYS_ALARM_STATE,
  input wire logic [15:0] PATTERN_LOCK_STATE,
  input wire logic [15:0] LOOP_UP_CODE_SEEN,
  input wire logic [16:0] SYS_BPV_EVENT,
  input wire logic [16:0] MISMATCH_EVENT,
  // Outputs
  input wire logic [15:0] LOOP_UP_STATE,
  input wire logic IRQ_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Completed write; only a write can release the interrupt
  wire wr_done = PSEL && PENABLE && PREADY && PWRITE;
  // Consecutive cycles of loop code on channel one
  int unsigned run_q;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      run_q <= 0;
    end else begin
      run_q <= LOOP_UP_CODE_SEEN[0] ? run_q + 1 : 0;
    end
  end
  a_bus_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_rdata_byte_only: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_alarm_rise_irq: assert property ((SYS_ALARM_STATE & ~$past(SYS_ALARM_STATE)) != 16'h0 |=> !IRQ_N)
    else $error("alarm rise without interrupt");
  a_lock_rise_irq: assert property ((PATTERN_LOCK_STATE & ~$past(PATTERN_LOCK_STATE)) != 16'h0 |=> !IRQ_N)
    else $error("lock rise without interrupt");
  a_bpv_sets_irq: assert property (SYS_BPV_EVENT != 17'h0 |=> !IRQ_N)
    else $error("violation without interrupt");
  a_mismatch_sets_irq: assert property (MISMATCH_EVENT != 17'h0 |=> !IRQ_N)
    else $error("mismatch without interrupt");
  a_irq_release_cause: assert property ($rose(IRQ_N) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("interrupt released without a write");
  a_loop_persist: assert property ($rose(LOOP_UP_STATE[0]) |-> run_q >= LOOP_SHORT_CYCLES)
    else $error("loop state rose too early");
  a_loop_drop: assert property (!LOOP_UP_CODE_SEEN[0] |-> ##2 !LOOP_UP_STATE[0])
    else $error("loop state held without code");
  // Main scenarios reached
  c_refused: cover property (PSLVERR);
  c_irq_release: cover property ($rose(IRQ_N));
  c_loop_up: cover property ($rose(LOOP_UP_STATE[0]));
endmodule

bind line_alarm_irq line_alarm_irq_properties #(.LOOP_SHORT_CYCLES(LOOP_SHORT_CYCLES)) props (
  .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SYS_ALARM_STATE(SYS_ALARM_STATE),
  .PATTERN_LOCK_STATE(PATTERN_LOCK_STATE), .LOOP_UP_CODE_SEEN(LOOP_UP_CODE_SEEN),
  .SYS_BPV_EVENT(SYS_BPV_EVENT), .MISMATCH_EVENT(MISMATCH_EVENT),
  .LOOP_UP_STATE(LOOP_UP_STATE), .IRQ_N(IRQ_N));

/* File: line_alarm_irq_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("FAIL %0t got %h expected %h", $time, got, exp); end end
module line_alarm_irq_test import lirq_pkg::*;;
  logic CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, irq_n;
  logic [15:0] PADDR, sa, la, pl, lc, ld, lus;
  logic [31:0] PWDATA, PRDATA;
  logic [16:0] sb, lb, se, le, mm;
  int error_cnt = 0;
  int samples_checked = 0;
  // Short counts keep the run brief
  line_alarm_irq #(.LOOP_SHORT_CYCLES(20), .LOOP_LONG_CYCLES(60), .ROUND_CYCLES(50)) dut (
    .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(4'hF), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SYS_ALARM_STATE(sa), .LINE_ALARM_STATE(la), .PATTERN_LOCK_STATE(pl),
    .LOOP_UP_CODE_SEEN(lc), .LOOP_DOWN_STATE(ld), .SYS_BPV_EVENT(sb), .LINE_BPV_EVENT(lb),
    .SYS_EXZ_EVENT(se), .LINE_EXZ_EVENT(le), .MISMATCH_EVENT(mm), .LOOP_UP_STATE(lus),
    .IRQ_N(irq_n));
  // 250 MHz clock
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // Register index of a channel copy
  function automatic logic [10:0] ix(input int c, input logic [5:0] off);
    return 11'(((c - 1) % 8) * 'h40 + ((c - 1) / 8) * 'h200) + {5'h0, off};
  endfunction
  // One transfer; request held until ready is sampled high, the watchdog bounds the wait
  task automatic apb(input logic w, input logic [10:0] idx, input logic [7:0] wd,
      output logic [31:0] d, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {3'h0, idx, 2'h0};
    PWDATA <= {24'h0, wd};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    d = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic put(input logic [10:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, idx, wd, d, e);
  endtask
  task automatic chk(input logic [10:0] idx, input logic [7:0] x, input logic xe);
    logic [31:0] d;
    logic e;
    apb(1'b0, idx, 8'h00, d, e);
    `CHK({e, d}, {xe, 24'h0, x})
  endtask
  // Events held for n cycles; all kinds or mismatch only
  task automatic pulse(input int c, input int n, input logic all);
    @(posedge CLK);
    {sb[c], lb[c], se[c], le[c]} <= {4{all}};
    mm[c] <= 1'b1;
    repeat (n) @(posedge CLK);
    {sb[c], lb[c], se[c], le[c], mm[c]} <= 5'h00;
  endtask
  // Manual count update, then both bytes
  task automatic snap(input int c, input logic [15:0] x);
    put(IDX_CNT_CTRL, 8'h01);
    repeat (3) @(posedge CLK);
    chk(ix(c, IDX_CNT_LO), x[7:0], 1'b0);
    chk(ix(c, IDX_CNT_HI), x[15:8], 1'b0);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, well past the expected length
  initial begin
    repeat (90000) @(posedge CLK);
    error_cnt++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    logic [31:0] d;
    logic e;
    logic [7:0] seen;
    logic [10:0] f;
    {RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {sa, la, pl, lc, ld, sb, lb, se, le, mm} = '0;
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    `CHK(irq_n, 1'b1)
    for (int c = 1; c <= 16; c++) begin
      chk(ix(c, IDX_FLAGS_B), RST_BYTE, 1'b0);
      chk(ix(c, IDX_CNT_LO), RST_BYTE, 1'b0);
    end
    chk(IDX_MON_FLAGS_B, RST_BYTE, 1'b0);
    chk(IDX_MON_CNT_LO, RST_BYTE, 1'b0);
    chk(11'h7E1, 8'h00, 1'b1);
    put(ix(3, IDX_CNT_LO), 8'hFF);
    chk(ix(3, IDX_CNT_LO), 8'h00, 1'b0);
    // Level edges on channel one under both edge selects
    for (int s = 0; s < 2; s++) begin
      put(IDX_CTRL, s ? 8'h61 : 8'h00);
      @(posedge CLK);
      {sa[0], la[0], pl[0], ld[0], lc[0]} <= 5'h1F;
      repeat (30) @(posedge CLK);
      `CHK(lus[0], 1'b1)
      `CHK(irq_n, 1'b0)
      chk(ix(1, IDX_FLAGS_A), 8'hE3, 1'b0);
      put(ix(1, IDX_FLAGS_A), 8'h00);
      chk(ix(1, IDX_FLAGS_A), 8'hE3, 1'b0);
      put(ix(1, IDX_FLAGS_A), 8'hFF);
      chk(ix(1, IDX_FLAGS_A), 8'h00, 1'b0);
      `CHK(irq_n, 1'b1)
      @(posedge CLK);
      {sa[0], la[0], pl[0], ld[0], lc[0]} <= 5'h00;
      repeat (4) @(posedge CLK);
      chk(ix(1, IDX_FLAGS_A), s ? 8'hE3 : 8'h00, 1'b0);
      put(ix(1, IDX_FLAGS_A), 8'hFF);
    end
    // Long persistence with auto loopback
    put(IDX_CNT_CTRL, 8'h08);
    @(posedge CLK);
    lc[0] <= 1'b1;
    repeat (40) @(posedge CLK);
    `CHK(lus[0], 1'b0)
    repeat (30) @(posedge CLK);
    `CHK(lus[0], 1'b1)
    lc[0] <= 1'b0;
    repeat (4) @(posedge CLK);
    put(ix(1, IDX_FLAGS_A), 8'hFF);
    // Event flags on the monitor and last channel; reserved bits ignored
    for (int k = 0; k < 2; k++) begin
      f = k ? ix(16, IDX_FLAGS_B) : IDX_MON_FLAGS_B;
      pulse(k ? 16 : 0, 1, 1'b1);
      chk(f, 8'h3E, 1'b0);
      put(f, 8'hC0);
      chk(f, 8'h3E, 1'b0);
      put(f, 8'hFF);
      chk(f, 8'h00, 1'b0);
    end
    // Counter snapshots and the wrap at the 65536th event
    pulse(5, 3, 1'b0);
    snap(5, 16'h0003);
    pulse(5, 300, 1'b0);
    snap(5, 16'h012C);
    put(ix(5, IDX_FLAGS_B), 8'hFF);
    pulse(5, 65535, 1'b0);
    chk(ix(5, IDX_FLAGS_B), 8'h02, 1'b0);
    pulse(5, 1, 1'b0);
    chk(ix(5, IDX_FLAGS_B), 8'h03, 1'b0);
    snap(5, 16'h0000);
    // Automatic rounds publish, then overwrite with an empty round
    put(IDX_CNT_CTRL, 8'h02);
    pulse(5, 7, 1'b0);
    seen = 8'h00;
    repeat (40) begin
      apb(1'b0, ix(5, IDX_CNT_LO), 8'h00, d, e);
      seen = seen | d[7:0];
    end
    `CHK(seen != 8'h00, 1'b1)
    `CHK(d[7:0], 8'h00)
    tally_and_finish();
  end
endmodule
